// >>> core/i2sap_cfg.svh
// Purpose: constants of the serial stereo audio port
// Assumes: 50 MHz system clock
// Notes: included by its bare name from every design file but the stream interface
`ifndef I2SAP_CFG_SVH
`define I2SAP_CFG_SVH

// ----------------------------------------------------------------
// clock and link timing
// ----------------------------------------------------------------
`define I2SAP_CLK_HZ 50000000
`define I2SAP_FRAME_RATE_HZ 48000
`define I2SAP_SLV_BCLK_MAX_HZ 3072000
`define I2SAP_PHASE_PCT 35
// least phase of the far clock in system cycles, rounded up
`define I2SAP_MIN_PHASE_CYC \
    ((`I2SAP_CLK_HZ / 1000 * `I2SAP_PHASE_PCT * 10 \
      + `I2SAP_SLV_BCLK_MAX_HZ - 1) / `I2SAP_SLV_BCLK_MAX_HZ)

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define I2SAP_WORD_BITS 16
`define I2SAP_FRAME_SHORT 32
`define I2SAP_FRAME_LONG 50
`define I2SAP_FIFO_DEPTH 16

// ----------------------------------------------------------------
// divider settings: toggle rate is clk * num / den
// ----------------------------------------------------------------
`define I2SAP_DIV_W 16
`define I2SAP_NUM_SHORT 192
`define I2SAP_DEN_SHORT 3125
`define I2SAP_NUM_LONG 12
`define I2SAP_DEN_LONG 125

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define I2SAP_RST_STATE '0

`endif

// >>> core/i2sap_pkg.sv
// Purpose: types of the serial stereo audio port
// Assumes: i2sap_cfg.svh holds the numbers
// Notes: core state is one packed struct
`include "i2sap_cfg.svh"

package i2sap_pkg;

    typedef logic [`I2SAP_WORD_BITS-1:0] i2sap_word_t;
    typedef logic [2*`I2SAP_WORD_BITS-1:0] i2sap_frame_t;

    typedef struct packed {
        logic bclk_s1;
        logic bclk_s2;
        logic bclk_s3;
        logic ws_s1;
        logic ws_s2;
        logic sdi_s1;
        logic sdi_s2;
        logic ws_gen;
        logic [5:0] bit_cnt;
        logic ws_seen;
        i2sap_word_t tx_sh;
        i2sap_word_t tx_right;
        logic [4:0] tx_cnt;
        logic sdo;
        i2sap_word_t rx_sh;
        logic [4:0] rx_cnt;
        i2sap_word_t rx_left;
        i2sap_frame_t rx_data;
        logic rx_valid;
        logic underrun;
    } i2sap_core_s;

endpackage : i2sap_pkg

// >>> core/i2sap_strm_if.sv
// Purpose: valid/ready word stream between the port's own modules
// Assumes: one clock shared by both ends
// Notes: snk takes words in, src hands words out
`timescale 1ns/1ps

interface i2sap_strm_if #(
    parameter int W = 32
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport snk (input valid, input data, output ready);
    modport src (output valid, output data, input ready);
endinterface : i2sap_strm_if

// >>> core/i2sap_fifo.sv
// Purpose: word fifo in the transmit path
// Assumes: depth is a power of two
// Notes: full and empty are exact; a push into full is refused
`timescale 1ns/1ps
`include "i2sap_cfg.svh"

module i2sap_fifo #(
    parameter int W = 32,
    parameter int DEPTH = `I2SAP_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    i2sap_strm_if.snk wr,
    i2sap_strm_if.src rd
);
    import i2sap_pkg::*;
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } i2sap_fifo_s;

    i2sap_fifo_s st_reg;
    i2sap_fifo_s st_next;
    logic [W-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign wr.ready = st_reg.count != (AW+1)'(DEPTH);
    assign rd.valid = st_reg.count != '0;
    assign rd.data = mem[st_reg.rptr];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wptr = st_reg.wptr + 1'b1;
        end
        if (pop) begin
            st_next.rptr = st_reg.rptr + 1'b1;
        end
        st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_reg <= `I2SAP_RST_STATE;
        end else begin
            st_reg <= st_next;
        end
        if (push) begin
            mem[st_reg.wptr] <= wr.data;
        end
    end

    fifo_bound_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_reg.count <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
    fifo_full_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !wr.ready && !pop |=> st_reg.count == $past(st_reg.count))
        else $error("fifo accepted a word while full");
    fifo_fill_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        !wr.ready);
endmodule : i2sap_fifo

// >>> core/i2sap_clkgen.sv
// Purpose: fractional bit clock generator for master mode
// Assumes: num below den, den nonzero
// Notes: each phase is floor or ceil of den/num cycles
`timescale 1ns/1ps
`include "i2sap_cfg.svh"

module i2sap_clkgen #(
    parameter int DW = `I2SAP_DIV_W
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_en,
    input wire logic [DW-1:0] i_num,
    input wire logic [DW-1:0] i_den,
    output logic o_bclk,
    output logic o_rise,
    output logic o_fall
);
    import i2sap_pkg::*;

    typedef struct packed {
        logic [DW-1:0] acc;
        logic bclk;
        logic rise;
        logic fall;
        logic [DW-1:0] phase;
    } i2sap_gen_s;

    i2sap_gen_s st_reg;
    i2sap_gen_s st_next;
    logic [DW:0] sum;

    always_comb begin
        st_next = st_reg;
        st_next.rise = 1'b0;
        st_next.fall = 1'b0;
        sum = {1'b0, st_reg.acc} + {1'b0, i_num};
        st_next.phase = st_reg.phase + 1'b1;
        if (!i_en) begin
            st_next = `I2SAP_RST_STATE;
        end else if (sum >= {1'b0, i_den}) begin
            // accumulator overflow toggles the clock
            st_next.acc = DW'(sum - {1'b0, i_den});
            st_next.bclk = !st_reg.bclk;
            st_next.rise = !st_reg.bclk;
            st_next.fall = st_reg.bclk;
            st_next.phase = '0;
        end else begin
            st_next.acc = DW'(sum);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_reg <= `I2SAP_RST_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_bclk = st_reg.bclk;
    assign o_rise = st_reg.rise;
    assign o_fall = st_reg.fall;

    // phases may differ by one cycle only, so the ratio stays fixed
    duty_fixed_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_en && $changed(st_reg.bclk) && $past(i_en, 2)
        && $past(st_reg.rise || st_reg.fall) == 1'b0
        |-> $past(st_reg.phase) + 1'b1 >= DW'(i_den / i_num)
        && $past(st_reg.phase) <= DW'(i_den / i_num))
        else $error("bit clock phase outside fixed ratio");
endmodule : i2sap_clkgen

// >>> core/i2sap_port.sv
// Purpose: serial stereo audio port, master or slave of bit clock
// Assumes: mode and divider inputs are static while a frame runs
// Notes: transmit frames buffered; received frames leave as pulses
`timescale 1ns/1ps
`include "i2sap_cfg.svh"

module i2sap_port (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_master,
    input wire logic i_frame50,
    input wire logic [`I2SAP_DIV_W-1:0] i_div_num,
    input wire logic [`I2SAP_DIV_W-1:0] i_div_den,
    input wire logic i_bclk,
    input wire logic i_ws,
    input wire logic i_sdi,
    output logic o_bclk,
    output logic o_bclk_oe,
    output logic o_ws,
    output logic o_ws_oe,
    output logic o_sdo,
    input wire logic i_tx_valid,
    input wire i2sap_pkg::i2sap_frame_t i_tx_data,
    output logic o_tx_ready,
    output i2sap_pkg::i2sap_frame_t o_rx_data,
    output logic o_rx_valid,
    output logic o_underrun
);
    import i2sap_pkg::*;

    localparam int WB = `I2SAP_WORD_BITS;
    localparam logic [5:0] HALF_SHORT = 6'(`I2SAP_FRAME_SHORT / 2);
    localparam logic [5:0] HALF_LONG = 6'(`I2SAP_FRAME_LONG / 2);
    localparam logic [4:0] WORD_END = 5'(WB);
    localparam int MIN_PHASE = `I2SAP_MIN_PHASE_CYC;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic i2sap_word_t shift_in(input i2sap_word_t w,
                                             input logic b);
        shift_in = {w[WB-2:0], b};
    endfunction : shift_in

    // ----------------------------------------------------------------
    // transmit buffer and bit clock generator
    // ----------------------------------------------------------------
    i2sap_strm_if #(.W(2*WB)) tx_in ();
    i2sap_strm_if #(.W(2*WB)) tx_out ();

    assign tx_in.valid = i_tx_valid;
    assign tx_in.data = i_tx_data;
    assign o_tx_ready = tx_in.ready;

    i2sap_fifo #(.W(2*WB), .DEPTH(`I2SAP_FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(tx_in),
        .rd(tx_out)
    );

    logic gen_bclk;
    logic gen_rise;
    logic gen_fall;

    i2sap_clkgen #(.DW(`I2SAP_DIV_W)) u_clkgen (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_en(i_master),
        .i_num(i_div_num),
        .i_den(i_div_den),
        .o_bclk(gen_bclk),
        .o_rise(gen_rise),
        .o_fall(gen_fall)
    );

    // ----------------------------------------------------------------
    // edges, slot tracking
    // ----------------------------------------------------------------
    i2sap_core_s st_reg;
    i2sap_core_s st_next;
    logic rise;
    logic fall;
    logic ws_now;
    logic slot_chg;
    logic [5:0] half;
    i2sap_word_t rx_word;

    // far clock edges seen on the synchronised copy
    assign rise = i_master ? gen_rise : (st_reg.bclk_s2 && !st_reg.bclk_s3);
    assign fall = i_master ? gen_fall : (!st_reg.bclk_s2 && st_reg.bclk_s3);
    assign ws_now = i_master ? st_reg.ws_gen : st_reg.ws_s2;
    assign slot_chg = rise && (ws_now != st_reg.ws_seen);
    assign half = i_frame50 ? HALF_LONG : HALF_SHORT;
    assign rx_word = shift_in(st_reg.rx_sh, st_reg.sdi_s2);
    // left slot opening pops one stereo frame
    assign tx_out.ready = slot_chg && !ws_now;

    always_comb begin
        st_next = st_reg;
        st_next.rx_valid = 1'b0;
        // two flops on every pin; rates up to the slave limit
        st_next.bclk_s1 = i_bclk;
        st_next.bclk_s2 = st_reg.bclk_s1;
        st_next.bclk_s3 = st_reg.bclk_s2;
        st_next.ws_s1 = i_ws;
        st_next.ws_s2 = st_reg.ws_s1;
        st_next.sdi_s1 = i_sdi;
        st_next.sdi_s2 = st_reg.sdi_s1;
        if (slot_chg) begin
            st_next.ws_seen = ws_now;
            st_next.rx_cnt = '0;
            st_next.tx_cnt = '0;
            if (st_reg.ws_seen) begin
                st_next.rx_data = {st_reg.rx_left,
                    (st_reg.rx_cnt < WORD_END) ? rx_word : st_reg.rx_sh};
                st_next.rx_valid = 1'b1;
            end else begin
                st_next.rx_left =
                    (st_reg.rx_cnt < WORD_END) ? rx_word : st_reg.rx_sh;
            end
            if (!ws_now) begin
                // empty fifo sends silence and flags the gap
                st_next.tx_sh = tx_out.valid ? tx_out.data[2*WB-1:WB] : '0;
                st_next.tx_right = tx_out.valid ? tx_out.data[WB-1:0] : '0;
                st_next.underrun = !tx_out.valid;
            end else begin
                st_next.tx_sh = st_reg.tx_right;
            end
        end else if (rise && st_reg.rx_cnt < WORD_END) begin
            // capture on rising edge, bits past the word dropped
            st_next.rx_sh = rx_word;
            st_next.rx_cnt = st_reg.rx_cnt + 1'b1;
        end
        if (fall) begin
            // msb on first fall after the change
            st_next.sdo = (st_reg.tx_cnt < WORD_END) ?
                st_reg.tx_sh[WB-1] : 1'b0;
            st_next.tx_sh = {st_reg.tx_sh[WB-2:0], 1'b0};
            if (st_reg.tx_cnt < WORD_END) begin
                st_next.tx_cnt = st_reg.tx_cnt + 1'b1;
            end
        end
        if (!i_master) begin
            st_next.ws_gen = 1'b0;
            st_next.bit_cnt = '0;
        end else if (fall) begin
            // word select flips on a fall, half a frame apart
            if (st_reg.bit_cnt == half - 1'b1) begin
                st_next.bit_cnt = '0;
                st_next.ws_gen = !st_reg.ws_gen;
            end else begin
                st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_reg <= `I2SAP_RST_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // pins and user outputs
    // ----------------------------------------------------------------
    // clock and select driven only as master
    assign o_bclk = i_master && gen_bclk;
    assign o_bclk_oe = i_master;
    assign o_ws = st_reg.ws_gen;
    assign o_ws_oe = i_master;
    assign o_sdo = st_reg.sdo;
    assign o_rx_data = st_reg.rx_data;
    assign o_rx_valid = st_reg.rx_valid;
    assign o_underrun = st_reg.underrun;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sdo_on_fall_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $changed(st_reg.sdo) |-> $past(fall))
        else $error("data out moved off a falling edge");

    rx_on_rise_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $changed(st_reg.rx_sh) |-> $past(rise) && !$past(slot_chg))
        else $error("receive shift moved off a rising edge");

    msb_first_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tx_out.ready && tx_out.valid
        |=> st_reg.tx_sh == $past(tx_out.data[2*WB-1:WB])
        && st_reg.tx_cnt == 5'h00)
        else $error("left word not loaded at slot start");

    msb_out_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        fall && st_reg.tx_cnt == 5'h00 && !slot_chg
        |=> st_reg.sdo == $past(st_reg.tx_sh[WB-1]))
        else $error("msb not sent on first fall of slot");

    zero_pad_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        fall && st_reg.tx_cnt >= WORD_END |=> !st_reg.sdo)
        else $error("nonzero bit past the word");

    left_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_reg.rx_valid |-> !st_reg.ws_seen && $past(st_reg.ws_seen))
        else $error("frame finished outside the left slot start");

    ws_period_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_master && $changed(st_reg.ws_gen) && $past(i_master)
        |-> $past(fall) && $past(st_reg.bit_cnt) == half - 1'b1)
        else $error("word select flipped at wrong bit");

    slave_quiet_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_master |=> !o_bclk && !o_ws_oe && !o_bclk_oe)
        else $error("pin driven in slave mode");

    edge_gap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_master && rise |=> !fall [*2])
        else $error("far clock phase too short to resolve");

    frame_rx_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        st_reg.rx_valid);
    underrun_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(st_reg.underrun));
    long_frame_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        i_master && i_frame50 && st_reg.bit_cnt == HALF_LONG - 1'b1);
    slave_pop_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_master && tx_out.ready && tx_out.valid);

    localparam int MIN_PHASE_USED = MIN_PHASE;
endmodule : i2sap_port

// >>> bench/i2sap_codec_model.sv
// Purpose: far-side audio codec facing the stereo audio port
// Assumes: the bench resolves the bit clock and word select wires
// Notes: makes the bit clock only when the port is slave
`timescale 1ns/1ps

module i2sap_codec_model (
    input wire logic i_rst,
    input wire logic i_bclk,
    input wire logic i_ws,
    input wire logic i_sdo,
    input wire logic [31:0] i_send,
    output logic o_bclk,
    output logic o_ws,
    output logic o_sdi,
    output logic [31:0] o_frame,
    output int o_nframes,
    output int o_pad_ones,
    output int o_edge_err
);
    logic ws_p = 1'h0;
    logic junk = 1'h0;
    logic [15:0] sh = 16'h0000;
    logic [15:0] left = 16'h0000;
    int pos = 16;

    initial begin
        o_bclk = 1'h0;
        o_ws = 1'h1;
        o_sdi = 1'h0;
        o_frame = 32'h0000_0000;
        o_nframes = 0;
        o_pad_ones = 0;
        o_edge_err = 0;
    end

    // ------------------------------------------------------------
    // receive side
    // ------------------------------------------------------------
    // one-bit delay: the rise that sees a new ws still ends the old slot
    always @(posedge i_bclk) begin
        if (pos < 16)
            sh = {sh[14:0], i_sdo};
        else if (i_sdo)
            o_pad_ones++;
        if (i_ws != ws_p) begin
            if (!ws_p)
                left = sh;
            else begin
                o_frame = {left, sh};
                o_nframes++;
            end
            ws_p = i_ws;
            pos = 0;
        end else
            pos++;
    end

    // stale bits would look like a frame after the port restarts
    always @(posedge i_rst) begin
        sh = 16'h0000;
        left = 16'h0000;
        pos = 16;
    end

    // the port may move sdo only while the clock is low
    always @(i_sdo)
        if (i_bclk === 1'h1 && !i_rst)
            o_edge_err++;

    // ------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------
    // pad slots carry a toggling pattern, never a held value
    always @(negedge i_bclk) begin
        junk = ~junk;
        if (pos >= 16)
            o_sdi = junk;
        else if (ws_p)
            o_sdi = i_send[15-pos];
        else
            o_sdi = i_send[31-pos];
    end

    // 340 ns bit, 170 ns phases: under 3.072 MHz, above 0.35 of 325 ns
    task automatic run_slave(input int frames, input int bits);
        #3ns;
        for (int s = 0; s < 2 * frames; s++) begin
            for (int b = 0; b < bits; b++) begin
                #170ns o_bclk = 1'h1;
                #170ns o_bclk = 1'h0;
                if (b == bits - 1)
                    o_ws = ~o_ws;
            end
        end
    endtask : run_slave
endmodule : i2sap_codec_model

// >>> bench/test_i2s_audio_port.sv
// Purpose: self-checking bench of the serial stereo audio port
// Assumes: 50 MHz clock, codec model on the far pins
// Notes: inputs change at the falling clock edge
`timescale 1ns/1ps
`include "i2sap_cfg.svh"

module test_i2s_audio_port;
    import i2sap_pkg::*;

    logic i_clk, i_sys_rst, i_master, i_frame50, i_tx_valid;
    logic [`I2SAP_DIV_W-1:0] i_div_num, i_div_den;
    i2sap_frame_t i_tx_data, o_rx_data, rx_last;
    logic o_bclk, o_bclk_oe, o_ws, o_ws_oe, o_sdo;
    logic o_tx_ready, o_rx_valid, o_underrun;
    logic m_bclk, m_ws, m_sdi, ws_d, bclk_d;
    logic [31:0] m_frame, send;
    logic [31:0] capq[$];
    int m_n, m_pad, m_edge, pad0, edge0, rx_n;
    int fail_count, checked;
    int cyc, run, brises, ws_per, bits_per, min_ph;
    wire bclk_w = o_bclk_oe ? o_bclk : m_bclk;
    wire ws_w = o_ws_oe ? o_ws : m_ws;

    i2sap_port uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_master(i_master), .i_frame50(i_frame50),
        .i_div_num(i_div_num), .i_div_den(i_div_den), .i_bclk(bclk_w),
        .i_ws(ws_w), .i_sdi(m_sdi), .o_bclk(o_bclk),
        .o_bclk_oe(o_bclk_oe), .o_ws(o_ws), .o_ws_oe(o_ws_oe),
        .o_sdo(o_sdo), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
        .o_tx_ready(o_tx_ready), .o_rx_data(o_rx_data),
        .o_rx_valid(o_rx_valid), .o_underrun(o_underrun));

    i2sap_codec_model codec (.i_rst(i_sys_rst), .i_bclk(bclk_w),
        .i_ws(ws_w), .i_sdo(o_sdo), .i_send(send), .o_bclk(m_bclk),
        .o_ws(m_ws), .o_sdi(m_sdi), .o_frame(m_frame), .o_nframes(m_n),
        .o_pad_ones(m_pad), .o_edge_err(m_edge));

    always #10ns i_clk = ~i_clk;

    // ------------------------------------------------------------
    // monitors
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        cyc++;
        if (o_bclk & !bclk_d)
            brises++;
        if (o_bclk != bclk_d) begin
            if (run < min_ph)
                min_ph = run;
            run = 1;
        end else
            run++;
        if (!o_ws & ws_d) begin
            ws_per = cyc;
            bits_per = brises;
            cyc = 0;
            brises = 0;
        end
        ws_d = o_ws;
        bclk_d = o_bclk;
        if (o_rx_valid === 1'h1) begin
            rx_last = o_rx_data;
            rx_n++;
        end
    end

    // underrun frames are all zero and are not collected
    always @(m_n)
        if (m_frame !== 32'h0)
            capq.push_back(m_frame);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic i2sap_frame_t frame_of(input int k);
        return 32'hC003_5AA5 + k * 32'h0101_0101;
    endfunction : frame_of

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic do_reset(input logic m, input logic f, input int num,
                            input int den, input int n);
        @(negedge i_clk);
        i_sys_rst = 1'h1;
        i_master = m;
        i_frame50 = f;
        i_div_num = num[`I2SAP_DIV_W-1:0];
        i_div_den = den[`I2SAP_DIV_W-1:0];
        repeat (n) @(negedge i_clk);
        i_sys_rst = 1'h0;
        capq.delete();
        rx_n = 0;
        min_ph = 999;
        pad0 = m_pad;
        edge0 = m_edge;
    endtask : do_reset

    // valid stays up; a word counts only where ready was high
    task automatic push_n(input int n, output int acc);
        acc = 0;
        for (int c = 0; c < n + 3 && acc < n; c++) begin
            @(negedge i_clk);
            i_tx_valid = 1'h1;
            i_tx_data = frame_of(acc);
            if (o_tx_ready === 1'h1)
                acc++;
        end
        @(negedge i_clk);
        i_tx_valid = 1'h0;
    endtask : push_n

    task automatic wait_drained(input int n);
        for (int c = 0; c < 40000 && capq.size() < n; c++)
            @(negedge i_clk);
        for (int c = 0; c < 3000 && o_underrun !== 1'h1; c++)
            @(negedge i_clk);
        check(o_underrun, 1'h1, "underrun after drain");
    endtask : wait_drained

    task automatic link_checks(input int bits, input int num, input int den);
        int lo;
        lo = `I2SAP_CLK_HZ / `I2SAP_FRAME_RATE_HZ;
        check(ws_per >= lo && ws_per <= lo + 1, 1, "frame rate");
        check(bits_per, bits, "clocks per frame");
        check(min_ph >= (70*den + 100*num - 1) / (100*num), 1, "phase");
    endtask : link_checks

    task automatic tail_checks(input int n);
        for (int k = 0; k < n; k++)
            check(capq[k], frame_of(k), "frame out");
        check(capq.size(), n, "frame count");
        check(m_pad - pad0, 0, "pad bits");
        check(m_edge - edge0, 0, "sdo moved on rise");
        check(rx_n > 0 && rx_last === send, 1, "frame in");
    endtask : tail_checks

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        do_reset(1'h1, 1'h0, `I2SAP_NUM_SHORT, `I2SAP_DEN_SHORT, 20);
        check({o_bclk_oe, o_ws_oe}, 2'h3, "master drives");
        check({o_bclk, o_ws, o_sdo}, 3'h0, "idle pins");
        check({o_tx_ready, o_rx_valid, o_underrun}, 3'h4, "flags");
        $display("test reset done, fails %0d", fail_count);
    endtask : t_reset

    task automatic t_master32;
        int acc;
        send = 32'h9A5C_3E71;
        do_reset(1'h1, 1'h0, `I2SAP_NUM_SHORT, `I2SAP_DEN_SHORT, 3);
        push_n(`I2SAP_FIFO_DEPTH + 1, acc);
        check(acc, `I2SAP_FIFO_DEPTH, "words taken");
        check(o_tx_ready, 1'h0, "full refuses");
        wait_drained(`I2SAP_FIFO_DEPTH);
        link_checks(`I2SAP_FRAME_SHORT, `I2SAP_NUM_SHORT, `I2SAP_DEN_SHORT);
        tail_checks(`I2SAP_FIFO_DEPTH);
        $display("test master 32 done, fails %0d", fail_count);
    endtask : t_master32

    task automatic t_master50;
        int acc;
        send = 32'h6B1D_F00F;
        do_reset(1'h1, 1'h1, `I2SAP_NUM_LONG, `I2SAP_DEN_LONG, 3);
        push_n(2, acc);
        check(acc, 2, "words taken");
        wait_drained(2);
        link_checks(`I2SAP_FRAME_LONG, `I2SAP_NUM_LONG, `I2SAP_DEN_LONG);
        tail_checks(2);
        $display("test master 50 done, fails %0d", fail_count);
    endtask : t_master50

    task automatic t_slave;
        int acc;
        send = 32'h5E3A_81C7;
        do_reset(1'h0, 1'h0, `I2SAP_NUM_SHORT, `I2SAP_DEN_SHORT, 3);
        check({o_bclk_oe, o_ws_oe, o_bclk, o_ws}, 4'h0, "slave pins");
        push_n(2, acc);
        codec.run_slave(5, 16);
        tail_checks(2);
        $display("test slave done, fails %0d", fail_count);
    endtask : t_slave

    task automatic final_report;
        $display("counts: checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    initial begin
        // reset from time zero so no edge ever sees unknown state
        {i_clk, i_sys_rst, i_master, i_frame50, i_tx_valid} = 5'h0E;
        i_div_num = `I2SAP_NUM_SHORT;
        i_div_den = `I2SAP_DEN_SHORT;
        i_tx_data = 32'h0;
        send = 32'h0;
        {ws_d, bclk_d} = 2'h0;
        {fail_count, checked, cyc, run, brises, ws_per, bits_per} = '0;
        t_reset();
        t_master32();
        t_master50();
        t_slave();
        final_report();
    end

    // the scenarios need about 24k cycles; cut at 75k
    initial begin
        #1500us;
        fail_count++;
        $display("BAD t=%0t watchdog expired", $time);
        final_report();
    end
endmodule : test_i2s_audio_port
